// ==== inc/edc_consts.vh ====
// edc_consts.vh: constants for the error-checked dram controller
// Summary of operation
// RQ1 - slave on a level-two system bus clocked by the 40MHz bus clock
// RQ2 - array data moves 128 bits at a time between controller and modules
// RQ3 - corrects single-bit errors, detects double-bit and one-nibble errors
// RQ4 - sixteen 36-bit modules in four groups of four identical modules
// RQ5 - each group configured alone: 4Mbit or 16Mbit, single or double sided
// RQ6 - capacity 16MB to 128MB in 16MB steps, then 64MB steps to 512MB
// RQ7 - writes narrower than 64 bits become read-modify-write cycles
// RQ8 - every bus transaction size and level-1 and level-2 types accepted
// RQ9 - uncorrectable data ends the bus cycle with an error acknowledge
// RQ10 - single-bit errors return corrected data with a normal acknowledge
// RQ11 - corrected errors can raise a level 15 interrupt request
// RQ12 - fault information captured for every single-bit and multi-bit error;
// while a fault is held, a later one only sets o_flt_lost (the code captures a fault that arrives in the clear cycle instead)
// RQ13 - fault address and correctability held until software clears them
`ifndef EDC_CONSTS_VH
`define EDC_CONSTS_VH
// address phase fields on the multiplexed bus
`define EDC_ADDR_HI 35
`define EDC_TY_HI 38
`define EDC_TY_LO 36
`define EDC_SZ_HI 41
`define EDC_SZ_LO 39
// transaction types
`define EDC_TY_WR 3'h0
`define EDC_TY_RD 3'h1
`define EDC_TY_CINV 3'h2
`define EDC_TY_CRD 3'h3
`define EDC_TY_CWI 3'h4
`define EDC_TY_CRI 3'h5
// size code of one doubleword, smaller codes are partial writes
`define EDC_SZ_DW 3'h3
`define EDC_DW_BYTES 36'h000000008
`define EDC_ONE_DW 5'h01
`define EDC_HALF_BIT 3
// address decode in 16MByte units
`define EDC_OUT_HI 35
`define EDC_OUT_LO 29
`define EDC_UNIT_HI 28
`define EDC_UNIT_LO 24
`define EDC_IDX_HI 26
`define EDC_IDX_LO 4
// per group strap: present, 16Mbit technology, double sided
`define EDC_CFG_PRES 2
`define EDC_CFG_T16 1
`define EDC_CFG_DBL 0
`define EDC_GSZ_4S 4'h1
`define EDC_GSZ_4D 4'h2
`define EDC_GSZ_16S 4'h4
`define EDC_GSZ_16D 4'h8
// check code: 72-bit codeword, positions 1..71
`define EDC_CW_TOP 8'h48
`define EDC_SYN_MAX 7'h47
// acknowledge codes as {err_b, rdy_b, rty_b}
`define EDC_ACK_IDLE 3'h7
`define EDC_ACK_DATA 3'h5
`define EDC_ACK_UE 3'h2
`endif

// ==== rtl/edc_secded.v ====
// edc_secded.v: 64-bit single-correct double-detect check code
`timescale 1ns/100ps
`default_nettype none
`include "edc_consts.vh"
module edc_secded (
  input wire [63:0] i_data,
  input wire [7:0] i_check,
  output reg [7:0] o_check,
  output reg [63:0] o_data,
  output reg o_ce,
  output reg o_ue
);
  reg [7:0] p;
  reg [6:0] d;
  reg [6:0] syn;
  reg par;

  always @* begin
    o_check = 8'h00;
    d = 7'h00;
    // data bits take the non power-of-two positions
    for (p = 8'h03; p < `EDC_CW_TOP; p = p + 8'h01) begin
      if ((p & (p - 8'h01)) != 8'h00) begin
        if (i_data[d[5:0]])
          o_check[6:0] = o_check[6:0] ^ p[6:0];
        d = d + 7'h01;
      end
    end
    o_check[7] = (^i_data) ^ (^o_check[6:0]);
    syn = o_check[6:0] ^ i_check[6:0];
    par = (^i_data) ^ (^i_check);
    o_data = i_data;
    o_ce = 1'b0;
    o_ue = 1'b0;
    if (par) begin
      // odd weight: single error unless the syndrome points nowhere
      if (syn > `EDC_SYN_MAX) begin
        o_ue = 1'b1; // [RQ3]
      end else begin
        o_ce = 1'b1; // [RQ3]
        d = 7'h00;
        for (p = 8'h03; p < `EDC_CW_TOP; p = p + 8'h01) begin
          if ((p & (p - 8'h01)) != 8'h00) begin
            if (p[6:0] == syn)
              o_data[d[5:0]] = ~o_data[d[5:0]];
            d = d + 7'h01;
          end
        end
      end
    end else if (syn != 7'h00) begin
      o_ue = 1'b1; // [RQ3]
    end
  end
endmodule // edc_secded
`default_nettype wire

// ==== rtl/edc_ctrl.v ====
// edc_ctrl.v: bus slave and array sequencer of the ecc dram controller
`timescale 1ns/100ps
`default_nettype none
`include "edc_consts.vh"
module edc_ctrl (
  input wire i_clock,
  input wire i_rst_b,
  input wire i_mas_b,
  input wire [63:0] i_mad,
  output reg [63:0] o_mad,
  output reg o_mad_oe,
  output reg o_mrdy_b,
  output wire o_mrdy_oe,
  output reg o_merr_b,
  output wire o_merr_oe,
  output reg o_mrty_b,
  output wire o_mrty_oe,
  input wire [11:0] i_grp_cfg,
  output reg o_mem_req,
  output reg [1:0] o_mem_we,
  output reg [1:0] o_mem_grp,
  output reg [22:0] o_mem_idx,
  output reg [127:0] o_mem_wdata,
  output reg [15:0] o_mem_wcheck,
  input wire i_mem_done,
  input wire [127:0] i_mem_rdata,
  input wire [15:0] i_mem_rcheck,
  input wire i_ce_int_en,
  input wire i_flt_clear,
  output reg o_irq15,
  output reg o_flt_valid,
  output reg o_flt_ue,
  output reg o_flt_lost,
  output reg [35:0] o_flt_addr
);
  localparam S_IDLE = 10'h001;
  localparam S_RREQ = 10'h002;
  localparam S_RWAIT = 10'h004;
  localparam S_RACK = 10'h008;
  localparam S_MERGE = 10'h010;
  localparam S_WTAKE = 10'h020;
  localparam S_WR = 10'h040;
  localparam S_WWAIT = 10'h080;
  localparam S_WGAP = 10'h100;
  localparam S_END = 10'h200;

  reg [9:0] st;
  reg [35:0] addr;
  reg [4:0] cnt;
  reg [2:0] siz;
  reg rmw;
  reg [5:0] gbase;
  reg [127:0] cor;
  reg [1:0] ue2;
  reg [63:0] wbuf;
  reg ack_oe;
  reg [11:0] cfg_s1;
  reg [11:0] cfg_s2;
  reg [11:0] cfg_s3;
  reg [11:0] cfg;
  reg [1:0] dgrp;
  reg [5:0] dbase;
  reg [63:0] mrg_m;
  integer j;

  assign o_mrdy_oe = ack_oe;
  assign o_merr_oe = ack_oe;
  assign o_mrty_oe = ack_oe;

  // group capacity in 16MByte units; absent groups take no space
  function [3:0] gsz;
    input [2:0] c;
    begin
      if (!c[`EDC_CFG_PRES])
        gsz = 4'h0;
      else if (c[`EDC_CFG_T16])
        gsz = c[`EDC_CFG_DBL] ? `EDC_GSZ_16D : `EDC_GSZ_16S;
      else
        gsz = c[`EDC_CFG_DBL] ? `EDC_GSZ_4D : `EDC_GSZ_4S;
    end
  endfunction

  // groups are stacked from address zero in group order
  wire [5:0] b1 = {2'b00, gsz(cfg[2:0])}; // [RQ5]
  wire [5:0] b2 = b1 + {2'b00, gsz(cfg[5:3])};
  wire [5:0] b3 = b2 + {2'b00, gsz(cfg[8:6])};
  wire [5:0] b4 = b3 + {2'b00, gsz(cfg[11:9])}; // [RQ6]
  wire [5:0] unit = {1'b0, i_mad[`EDC_UNIT_HI:`EDC_UNIT_LO]};
  wire hit = ~|i_mad[`EDC_OUT_HI:`EDC_OUT_LO] && (unit < b4);
  wire [2:0] ty = i_mad[`EDC_TY_HI:`EDC_TY_LO];
  wire [2:0] sz = i_mad[`EDC_SZ_HI:`EDC_SZ_LO];
  wire is_wr = (ty == `EDC_TY_WR) || (ty == `EDC_TY_CWI);
  wire is_inv = (ty == `EDC_TY_CINV);

  always @* begin
    if (unit < b1) begin
      dgrp = 2'h0;
      dbase = 6'h00;
    end else if (unit < b2) begin
      dgrp = 2'h1;
      dbase = b1;
    end else if (unit < b3) begin
      dgrp = 2'h2;
      dbase = b2;
    end else begin
      dgrp = 2'h3;
      dbase = b3;
    end
  end

  wire [5:0] uoff = {1'b0, addr[`EDC_UNIT_HI:`EDC_UNIT_LO]} - gbase;
  wire [28:0] offs = {uoff[4:0], addr[`EDC_UNIT_LO-1:0]};
  wire half = addr[`EDC_HALF_BIT];

  // array word carries two interleaved codewords: each nibble holds two
  // bits of each, so any damage inside one nibble is at most a double
  // error per codeword and is reported, never miscorrected
  wire [63:0] ra;
  wire [63:0] rb;
  wire [7:0] rca;
  wire [7:0] rcb;
  wire [63:0] dac;
  wire [63:0] dbc;
  wire ace;
  wire aue;
  wire bce;
  wire bue;
  wire [7:0] wck8;
  wire [127:0] wpk;
  wire [15:0] wckpk;
  genvar n;
  generate
    for (n = 0; n < 32; n = n + 1) begin : g_nib
      assign ra[2*n+1:2*n] = i_mem_rdata[4*n+1:4*n]; // [RQ3]
      assign rb[2*n+1:2*n] = i_mem_rdata[4*n+3:4*n+2];
      assign wpk[4*n+3:4*n] = {wbuf[2*n+1:2*n], wbuf[2*n+1:2*n]};
    end
    for (n = 0; n < 4; n = n + 1) begin : g_cnib
      assign rca[2*n+1:2*n] = i_mem_rcheck[4*n+1:4*n];
      assign rcb[2*n+1:2*n] = i_mem_rcheck[4*n+3:4*n+2];
      assign wckpk[4*n+3:4*n] = {wck8[2*n+1:2*n], wck8[2*n+1:2*n]};
    end
  endgenerate

  edc_secded u_deca (
    .i_data(ra),
    .i_check(rca),
    .o_check(),
    .o_data(dac),
    .o_ce(ace),
    .o_ue(aue)
  );
  edc_secded u_decb (
    .i_data(rb),
    .i_check(rcb),
    .o_check(),
    .o_data(dbc),
    .o_ce(bce),
    .o_ue(bue)
  );
  edc_secded u_enc (
    .i_data(wbuf),
    .i_check(8'h00),
    .o_check(wck8),
    .o_data(),
    .o_ce(),
    .o_ue()
  );

  // byte lanes of a partial write, byte 0 in the top lane
  always @* begin
    mrg_m = 64'h0000000000000000;
    for (j = 0; j < 8; j = j + 1) begin
      if (j >= addr[2:0] && j < addr[2:0] + (4'h1 << siz))
        mrg_m[63-8*j -: 8] = 8'hFF; // [RQ7]
    end
  end

  wire [63:0] hdat = half ? cor[127:64] : cor[63:0];
  wire [63:0] merged = (hdat & ~mrg_m) | (i_mad & mrg_m);
  wire rd_err = (st == S_RWAIT) && i_mem_done && (ace | aue | bce | bue);

  // group straps: three stages, a change taken once stages two and three agree
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_s1 <= 12'h000;
      cfg_s2 <= 12'h000;
      cfg_s3 <= 12'h000;
      cfg <= 12'h000;
    end else begin
      cfg_s1 <= i_grp_cfg;
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      cfg <= (cfg_s2 & cfg_s3) | (cfg & (cfg_s2 | cfg_s3)); // [RQ5]
    end
  end

  // fault capture: first fault held, a new one in the clear cycle wins
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flt_valid <= 1'b0;
      o_flt_ue <= 1'b0;
      o_flt_lost <= 1'b0;
      o_flt_addr <= 36'h000000000;
      o_irq15 <= 1'b0;
    end else begin
      if (rd_err) begin
        if (o_flt_valid && !i_flt_clear) begin
          o_flt_lost <= 1'b1; // [RQ12]
        end else begin
          o_flt_valid <= 1'b1; // [RQ12]
          o_flt_ue <= aue | bue; // [RQ13]
          o_flt_addr <= {addr[35:4], 4'h0}; // [RQ13]
          o_flt_lost <= 1'b0;
        end
      end else if (i_flt_clear) begin
        o_flt_valid <= 1'b0; // [RQ13]
        o_flt_lost <= 1'b0;
      end
      o_irq15 <= i_ce_int_en & o_flt_valid & ~o_flt_ue; // [RQ11]
    end
  end

  // bus slave sequencer, runs on the bus clock itself
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= S_IDLE;
      addr <= 36'h000000000;
      cnt <= 5'h00;
      siz <= 3'h0;
      rmw <= 1'b0;
      gbase <= 6'h00;
      cor <= 128'h0;
      ue2 <= 2'h0;
      wbuf <= 64'h0000000000000000;
      ack_oe <= 1'b0;
      {o_merr_b, o_mrdy_b, o_mrty_b} <= `EDC_ACK_IDLE;
      o_mad <= 64'h0000000000000000;
      o_mad_oe <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 2'h0;
      o_mem_grp <= 2'h0;
      o_mem_idx <= 23'h000000;
      o_mem_wdata <= 128'h0;
      o_mem_wcheck <= 16'h0000;
    end else begin
      {o_merr_b, o_mrdy_b, o_mrty_b} <= `EDC_ACK_IDLE;
      o_mad_oe <= 1'b0;
      o_mem_req <= 1'b0;
      case (st)
        S_IDLE: begin
          ack_oe <= 1'b0;
          if (!i_mas_b && hit) begin // [RQ1]
            siz <= sz;
            o_mem_grp <= dgrp; // [RQ4]
            gbase <= dbase;
            rmw <= is_wr && (sz < `EDC_SZ_DW);
            ack_oe <= 1'b1;
            // bursts start at the first doubleword of their size-aligned block
            if (sz < `EDC_SZ_DW) begin
              addr <= i_mad[35:0];
              cnt <= `EDC_ONE_DW;
            end else begin
              addr <= i_mad[35:0] & ~((36'h1 << sz) - 36'h1); // [RQ8]
              cnt <= `EDC_ONE_DW << (sz - `EDC_SZ_DW);
            end
            if (is_inv) begin
              {o_merr_b, o_mrdy_b, o_mrty_b} <= `EDC_ACK_DATA; // [RQ8]
              st <= S_END;
            end else if (is_wr && sz >= `EDC_SZ_DW)
              st <= S_WTAKE;
            else
              st <= S_RREQ; // [RQ7]
          end
        end
        S_RREQ: begin
          o_mem_req <= 1'b1;
          o_mem_we <= 2'h0;
          o_mem_idx <= offs[`EDC_IDX_HI:`EDC_IDX_LO];
          st <= S_RWAIT;
        end
        S_RWAIT: begin
          if (i_mem_done) begin
            cor <= {dbc, dac}; // [RQ2]
            ue2 <= {bue, aue};
            st <= rmw ? S_MERGE : S_RACK;
          end
        end
        S_RACK: begin
          o_mad <= hdat; // [RQ10]
          o_mad_oe <= 1'b1;
          addr <= addr + `EDC_DW_BYTES;
          cnt <= cnt - `EDC_ONE_DW;
          if (ue2[half]) begin
            {o_merr_b, o_mrdy_b, o_mrty_b} <= `EDC_ACK_UE; // [RQ9]
            st <= S_END;
          end else begin
            {o_merr_b, o_mrdy_b, o_mrty_b} <= `EDC_ACK_DATA; // [RQ10]
            if (cnt == `EDC_ONE_DW)
              st <= S_END;
            else if (half)
              st <= S_RREQ;
          end
        end
        S_MERGE: begin
          // a failed read aborts the write and leaves memory untouched
          if (ue2[half]) begin
            {o_merr_b, o_mrdy_b, o_mrty_b} <= `EDC_ACK_UE; // [RQ9]
            st <= S_END;
          end else begin
            wbuf <= merged; // [RQ7]
            st <= S_WR;
          end
        end
        S_WTAKE: begin
          wbuf <= i_mad;
          st <= S_WR;
        end
        S_WR: begin
          o_mem_req <= 1'b1;
          o_mem_we <= half ? 2'h2 : 2'h1;
          o_mem_idx <= offs[`EDC_IDX_HI:`EDC_IDX_LO];
          o_mem_wdata <= wpk; // [RQ2]
          o_mem_wcheck <= wckpk; // [RQ3]
          st <= S_WWAIT;
        end
        S_WWAIT: begin
          if (i_mem_done) begin
            {o_merr_b, o_mrdy_b, o_mrty_b} <= `EDC_ACK_DATA;
            addr <= addr + `EDC_DW_BYTES;
            cnt <= cnt - `EDC_ONE_DW;
            st <= (cnt == `EDC_ONE_DW) ? S_END : S_WGAP;
          end
        end
        S_WGAP: begin
          // master moves to the next doubleword only after seeing ready
          st <= S_WTAKE;
        end
        S_END: begin
          st <= S_IDLE;
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end
endmodule // edc_ctrl
`default_nettype wire

// ==== tb/edc_ctrl_monitor.sv ====
// edc_ctrl_monitor.sv: port checks for the controller
`timescale 1ns/100ps
`default_nettype none
module edc_ctrl_mon (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_ce_int_en,
  input wire logic i_flt_clear,
  input wire logic i_mem_done,
  input wire logic o_mad_oe,
  input wire logic o_mrdy_b,
  input wire logic o_mrdy_oe,
  input wire logic o_merr_b,
  input wire logic o_mrty_b,
  input wire logic o_mem_req,
  input wire logic o_irq15,
  input wire logic o_flt_valid,
  input wire logic o_flt_ue,
  input wire logic o_flt_lost,
  input wire logic [35:0] o_flt_addr
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_ack_driven: assert property (
    (!o_mrdy_b || !o_merr_b) |-> o_mrdy_oe)
    else $error("ack low while not driven");
  a_mad_in_ack: assert property (
    o_mad_oe |-> (!o_mrdy_b || !o_merr_b))
    else $error("read data driven outside an ack");
  a_ue_ack_code: assert property (!o_merr_b |-> o_mrdy_b && !o_mrty_b
    ##1 o_merr_b && o_mrdy_b) else $error("bad uncorrectable ack");
  a_req_pulse: assert property (o_mem_req |=> !o_mem_req)
    else $error("array request longer than one cycle");
  a_irq_cause: assert property (o_irq15 |-> $past(o_flt_valid)
    && !$past(o_flt_ue) && $past(i_ce_int_en))
    else $error("irq without cause");
  a_fault_held: assert property (o_flt_valid && !i_flt_clear
    |=> o_flt_valid && $stable(o_flt_addr)) else $error("fault not held");
  a_fault_cause: assert property ($rose(o_flt_valid)
    |-> $past(i_mem_done) || $past(i_mem_done, 2))
    else $error("fault w/o read");
  a_lost_cause: assert property (
    $rose(o_flt_lost) |-> $past(o_flt_valid))
    else $error("lost set with no fault held");
endmodule // edc_ctrl_mon
bind edc_ctrl edc_ctrl_mon u_mon (.*);
`default_nettype wire

// ==== tb/edc_mem_model.sv ====
// edc_mem_model.sv: behavioural dram array behind the controller
`timescale 1ns/100ps
`default_nettype none
module edc_mem_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_req,
  input wire logic [1:0] i_we,
  input wire logic [22:0] i_idx,
  input wire logic [127:0] i_wdata,
  input wire logic [15:0] i_wcheck,
  input wire logic [127:0] i_flip,
  input wire logic i_slow,
  output logic o_done,
  output logic [127:0] o_rdata,
  output logic [15:0] o_rcheck
);
  logic [143:0] mem [0:15];
  logic [143:0] wd, msk;
  logic [3:0] idx;
  logic [1:0] we;
  logic [2:0] cnt;
  // all-zero words carry a valid code, so unwritten reads stay clean
  initial for (int k = 0; k < 16; k++) mem[k] = '0;
  assign msk = (we == 2'h1) ? {16'h3333, {32{4'h3}}} :
               (we == 2'h2) ? {16'hCCCC, {32{4'hC}}} : '0;
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 3'h0;
      o_done <= 1'b0;
      {o_rcheck, o_rdata} <= '0;
    end else begin
      o_done <= 1'b0;
      // data is only valid with done; toggle so stale values never match
      {o_rcheck, o_rdata} <= ~{o_rcheck, o_rdata};
      if (i_req) begin
        cnt <= i_slow ? 3'h5 : 3'h1;
        idx <= i_idx[3:0];
        we <= i_we;
        wd <= {i_wcheck, i_wdata};
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          o_done <= 1'b1;
          mem[idx] <= (mem[idx] & ~msk) | (wd & msk);
          {o_rcheck, o_rdata} <= mem[idx] ^ {16'h0000, i_flip};
        end
      end
    end
  end
endmodule // edc_mem_model
`default_nettype wire

// ==== tb/test_edc_ctrl.sv ====
// test_edc_ctrl.sv: self-checking bench for the ecc dram controller
`timescale 1ns/100ps
`default_nettype none
module test_edc_ctrl;
  logic i_clock, i_rst_b, i_mas_b, i_mem_done, i_ce_int_en, i_flt_clear;
  logic o_mad_oe, o_mrdy_b, o_mrdy_oe, o_merr_b, o_merr_oe, o_mrty_b;
  logic o_mrty_oe, o_mem_req, o_irq15, o_flt_valid, o_flt_ue, o_flt_lost;
  logic slow;
  logic [63:0] i_mad, o_mad, dw_a, dw_b, q, q2;
  logic [11:0] i_grp_cfg;
  logic [1:0] o_mem_we, o_mem_grp;
  logic [22:0] o_mem_idx;
  logic [127:0] o_mem_wdata, i_mem_rdata, flip;
  logic [15:0] o_mem_wcheck, i_mem_rcheck;
  logic [35:0] o_flt_addr;
  logic [2:0] c, oe;
  int n, error_cnt, comparisons;
  edc_ctrl dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_mas_b(i_mas_b),
    .i_mad(i_mad), .o_mad(o_mad), .o_mad_oe(o_mad_oe), .o_mrdy_b(o_mrdy_b),
    .o_mrdy_oe(o_mrdy_oe), .o_merr_b(o_merr_b), .o_merr_oe(o_merr_oe),
    .o_mrty_b(o_mrty_b), .o_mrty_oe(o_mrty_oe), .i_grp_cfg(i_grp_cfg),
    .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_grp(o_mem_grp),
    .o_mem_idx(o_mem_idx), .o_mem_wdata(o_mem_wdata),
    .o_mem_wcheck(o_mem_wcheck), .i_mem_done(i_mem_done),
    .i_mem_rdata(i_mem_rdata), .i_mem_rcheck(i_mem_rcheck),
    .i_ce_int_en(i_ce_int_en), .i_flt_clear(i_flt_clear), .o_irq15(o_irq15),
    .o_flt_valid(o_flt_valid), .o_flt_ue(o_flt_ue), .o_flt_lost(o_flt_lost),
    .o_flt_addr(o_flt_addr));
  edc_mem_model u_mem (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_req(o_mem_req), .i_we(o_mem_we), .i_idx(o_mem_idx),
    .i_wdata(o_mem_wdata), .i_wcheck(o_mem_wcheck), .i_flip(flip),
    .i_slow(slow), .o_done(i_mem_done), .o_rdata(i_mem_rdata),
    .o_rcheck(i_mem_rcheck));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask
  // one bus transaction; the data word is held until the ack has passed
  task automatic bus(input logic [2:0] sz, ty, input logic [35:0] a,
      input logic [63:0] d, output logic [2:0] ack, output logic [63:0] rd,
      output int cnt);
    int t;
    ack = 3'h7;
    rd = 64'h0;
    cnt = 0;
    i_mas_b = 1'b0;
    i_mad = {22'h0, sz, ty, a};
    @(negedge i_clock);
    i_mas_b = 1'b1;
    i_mad = d;
    // an invalidate is acknowledged in the very first data cycle
    for (t = 0; t < 80 && (cnt == 0 || o_mrdy_oe === 1'b1); t++) begin
      if ({o_merr_b, o_mrdy_b, o_mrty_b} !== 3'h7) begin
        if (cnt == 0) begin
          ack = {o_merr_b, o_mrdy_b, o_mrty_b};
          rd = o_mad;
          oe = {o_merr_oe, o_mrty_oe, o_mad_oe};
        end
        q2 = o_mad;
        cnt++;
      end
      @(negedge i_clock);
    end
    if (t == 80) begin
      error_cnt++;
      $display("wrong value at %0t: bus timeout", $time);
      wrap_up;
    end
    @(negedge i_clock);
  endtask
  task automatic clr;
    i_flt_clear = 1'b1;
    @(negedge i_clock);
    i_flt_clear = 1'b0;
    @(negedge i_clock);
  endtask
  task automatic sc_rw;
    bus(3'h3, 3'h0, 36'h100, dw_a, c, q, n);
    check(c, 3'h5, "write ack");
    check(oe, 3'h6, "write oe");
    bus(3'h3, 3'h0, 36'h108, dw_b, c, q, n);
    for (int t = 1; t < 6; t += 2) begin
      bus(3'h3, t[2:0], 36'h108, 64'h0, c, q, n);
      check(q, dw_b, "read data");
      check(oe, 3'h7, "read oe");
    end
  endtask
  task automatic sc_partial;
    bus(3'h0, 3'h0, 36'h103, 64'h000000A500000000, c, q, n);
    check(c, 3'h5, "byte write ack");
    dw_a[39:32] = 8'hA5;
    bus(3'h3, 3'h1, 36'h100, 64'h0, c, q, n);
    check(q, dw_a, "merged data");
  endtask
  task automatic sc_errors;
    i_ce_int_en = 1'b1;
    flip = 128'h1;
    bus(3'h3, 3'h1, 36'h100, 64'h0, c, q, n);
    check(c, 3'h5, "corrected ack");
    check(q, dw_a, "corrected data");
    check({o_flt_valid, o_flt_ue, o_flt_addr}, 38'h2000000100, "ce");
    check(o_irq15, 1'b1, "ce irq");
    clr;
    check(o_flt_valid, 1'b0, "clear");
    flip = 128'h3;
    bus(3'h3, 3'h1, 36'h100, 64'h0, c, q, n);
    check(c, 3'h2, "double ack");
    check(o_flt_ue, 1'b1, "ue flag");
    flip = 128'hF;
    bus(3'h3, 3'h1, 36'h100, 64'h0, c, q, n);
    check(c, 3'h2, "nibble ack");
    check({o_flt_lost, o_irq15}, 2'h2, "lost");
    flip = 128'h0;
    clr;
    check({o_flt_valid, o_flt_lost}, 2'h0, "ue clear");
  endtask
  task automatic sc_burst;
    slow = 1'b1;
    bus(3'h4, 3'h1, 36'h108, 64'h0, c, q, n);
    check(n, 2, "burst beats");
    check(q, dw_a, "burst first");
    check(q2, dw_b, "burst last");
    slow = 1'b0;
  endtask
  // invalidate, then a second group of a different size and a burst write
  task automatic sc_more;
    bus(3'h3, 3'h2, 36'h200, 64'h0, c, q, n);
    check({c, oe}, 6'h2E, "inval ack");
    check(n, 1, "inval beats");
    i_grp_cfg = 12'h03C;
    repeat (6) @(negedge i_clock);
    bus(3'h4, 3'h4, 36'h1000120, dw_b, c, q, n);
    check(n, 2, "burst write beats");
    check({o_mem_grp, o_mem_idx}, {2'h1, 23'h000012}, "group");
    bus(3'h4, 3'h3, 36'h1000128, 64'h0, c, q, n);
    check(q, dw_b, "group first");
    check(q2, dw_b, "group last");
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_mas_b = 1'b1;
    i_mad = 64'h0;
    i_grp_cfg = 12'h004;
    i_ce_int_en = 1'b0;
    i_flt_clear = 1'b0;
    flip = 128'h0;
    slow = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    dw_a = 64'h0123456789ABCDEF;
    dw_b = 64'hFEDCBA9876543210;
    repeat (16) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clock);
    sc_rw;
    sc_partial;
    sc_errors;
    sc_burst;
    sc_more;
    wrap_up;
  end
endmodule // test_edc_ctrl
`default_nettype wire
